// >>> rtl/trch_handler.sv
// Purpose: serves read-tag commands, answers ack byte then tag data
// Assumes: host bytes and tag answers come from logic on i_core_clk
// Notes:   reply bytes pass a fifo so a slow host stalls the handler
// Function
// - in password mode only a configuration byte of 06h or 46h counts as a usable tag.
// - the configuration byte is byte 0 of page 3 of the transponder.
// - in 40-bit mode a good read returns the ack byte then five data bytes, MSB first.
// - the ack byte has bits 7 and 6 set, status flags in bits 5..1 and bit 0 unused.
// - when the ack carries an error no data byte follows it.
// - in 128-bit mode a good read returns the ack byte then sixteen data bytes, MSB first.
// - in 128-bit mode only an RF/64 direct ASK Manchester stream with header 802Ah is taken.
`timescale 1ns/1ps

module trch_fifo #(
	parameter int WIDTH = trch_pkg::FIFO_W,
	parameter int DEPTH = trch_pkg::FIFO_D
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic      [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	// pointer wrap relies on a power of two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	logic             push;
	logic             pop;
	assign o_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign o_valid = wr_r != rd_r;
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem_r[rd_r[AW-1:0]];
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push) wr_r <= wr_r + 1'b1;
			if (pop) rd_r <= rd_r + 1'b1;
		end
		if (push) mem_r[wr_r[AW-1:0]] <= i_data;
	end
endmodule : trch_fifo

module trch_handler #(
	parameter int DEPTH = trch_pkg::FIFO_D
) (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire trch_pkg::trch_mode_t   i_mode,
	input  wire trch_pkg::trch_byte_t   i_cmd,
	output logic                        o_cmd_ready,
	output trch_pkg::trch_byte_t        o_rsp,
	input  wire logic                   i_rsp_ready,
	output logic                        o_tag_req,
	output logic [2:0]                  o_tag_page,
	input  wire trch_pkg::trch_tag_rsp_t i_tag,
	output logic                        o_busy
);
	typedef enum logic [2:0] {ST_IDLE, ST_ARG, ST_REQ, ST_WAIT, ST_ACK, ST_DATA} trch_state_t;
	typedef struct packed {
		trch_state_t  st;
		logic [7:0]   ack;
		logic [4:0]   left;
		logic [127:0] shift;
		logic [2:0]   page;
	} trch_regs_t;

	trch_regs_t           s_r;
	trch_regs_t           s_nxt;
	logic                 f_ready;
	trch_pkg::trch_byte_t push;
	logic [7:0]           cfg_byte;
	logic                 cfg_usable;
	logic                 hdr_usable;

	function automatic logic [4:0] reply_len(input trch_pkg::trch_mode_t m);
		case (m)
			trch_pkg::TRCH_MODE_40:  reply_len = trch_pkg::LEN_40;
			trch_pkg::TRCH_MODE_128: reply_len = trch_pkg::LEN_128;
			default:                 reply_len = trch_pkg::LEN_PW;
		endcase
	endfunction : reply_len

	assign cfg_byte   = i_tag.cfg_word[31:24];
	assign cfg_usable = cfg_byte == trch_pkg::CFG_OPEN || cfg_byte == trch_pkg::CFG_LOCKED;
	assign hdr_usable = i_tag.header == trch_pkg::HDR_128 && i_tag.rf64_ask_manch;

	always_comb begin
		s_nxt     = s_r;
		push      = '0;
		o_tag_req = 1'b0;
		case (s_r.st)
			ST_IDLE: if (i_cmd.valid && i_cmd.data == trch_pkg::CMD_READ) s_nxt.st = ST_ARG;
			ST_ARG: if (i_cmd.valid) begin
				// page bits only matter in password mode; others treat it as dummy
				s_nxt.page = (i_mode == trch_pkg::TRCH_MODE_PW) ? i_cmd.data[2:0] : 3'h0;
				s_nxt.st   = ST_REQ;
			end
			ST_REQ: begin
				o_tag_req = 1'b1;
				s_nxt.st  = ST_WAIT;
			end
			ST_WAIT: if (i_tag.done) begin
				s_nxt.st    = ST_ACK;
				s_nxt.left  = reply_len(i_mode);
				s_nxt.ack   = {trch_pkg::ACK_BASE[7:6], trch_pkg::FLAG_NO_TAG, 1'b0};
				s_nxt.shift = i_tag.data;
				case (i_mode)
					trch_pkg::TRCH_MODE_40: begin
						s_nxt.shift = {i_tag.data[39:0], 88'h0};
						if (i_tag.present) s_nxt.ack[5:1] = trch_pkg::FLAG_OK;
					end
					trch_pkg::TRCH_MODE_128: begin
						if (i_tag.present && hdr_usable) s_nxt.ack[5:1] = trch_pkg::FLAG_OK;
					end
					default: begin
						s_nxt.shift = {i_tag.data[31:0], 96'h0};
						if (i_tag.present && cfg_usable)
							s_nxt.ack[5:1] = i_tag.pw_ok ? trch_pkg::FLAG_OK : trch_pkg::FLAG_TAG_PW;
					end
				endcase
			end
			ST_ACK: if (f_ready) begin
				push = '{valid: 1'b1, data: s_r.ack};
				// error ack closes the transaction at once
				s_nxt.st = (s_r.ack[5:1] == trch_pkg::FLAG_OK) ? ST_DATA : ST_IDLE;
			end
			ST_DATA: if (f_ready) begin
				push        = '{valid: 1'b1, data: s_r.shift[127:120]};
				s_nxt.shift = {s_r.shift[119:0], 8'h00};
				s_nxt.left  = s_r.left - 5'h01;
				if (s_r.left == 5'h01) s_nxt.st = ST_IDLE;
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			s_r <= '{st: ST_IDLE, ack: 8'h00, left: 5'h00, shift: 128'h0, page: 3'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// stray bytes outside a command are swallowed so the host cannot wedge us
	assign o_cmd_ready = s_r.st == ST_IDLE || s_r.st == ST_ARG;
	assign o_tag_page  = s_r.page;
	assign o_busy      = s_r.st != ST_IDLE;

	trch_fifo #(.WIDTH(trch_pkg::FIFO_W), .DEPTH(DEPTH)) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.i_valid   (push.valid),
		.o_ready   (f_ready),
		.i_data    (push.data),
		.o_valid   (o_rsp.valid),
		.i_ready   (i_rsp_ready),
		.o_data    (o_rsp.data)
	);

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_read_cmd;
		s_r.st == ST_IDLE && i_cmd.valid && i_cmd.data == trch_pkg::CMD_READ ##1 i_cmd.valid;
	endsequence
	sequence s_good_ack;
		s_r.st == ST_ACK && f_ready && s_r.ack[5:1] == trch_pkg::FLAG_OK;
	endsequence
	sequence s_tag_done;
		s_r.st == ST_WAIT && i_tag.done;
	endsequence

	a_cmd_arg_req: assert property (s_read_cmd |=> o_tag_req ##1 !o_tag_req)
		else $error("read command did not raise one tag request");
	a_ack_top_bits: assert property (s_r.st == ST_ACK && f_ready |-> push.data[7:6] == 2'b11)
		else $error("ack byte top bits not set");
	a_err_no_data: assert property (s_r.st == ST_ACK && f_ready && s_r.ack[5:1] != trch_pkg::FLAG_OK
		|=> s_r.st == ST_IDLE)
		else $error("data followed an error ack");
	// mode is sampled at done, so it must not move under the ack
	a_len_forty: assert property ((s_good_ack and (i_mode == trch_pkg::TRCH_MODE_40 && $stable(i_mode)))
		|=> s_r.left == 5'h05 && s_r.st == ST_DATA)
		else $error("40-bit reply length wrong");
	a_len_wide: assert property ((s_good_ack and (i_mode == trch_pkg::TRCH_MODE_128))
		|=> s_r.left == 5'h10)
		else $error("128-bit reply length wrong");
	a_cfg_reject: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_PW && !cfg_usable))
		|=> s_r.ack == 8'hC0)
		else $error("unusable config byte accepted");
	a_cfg_source: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_PW && i_tag.present
		&& i_tag.pw_ok && i_tag.cfg_word[31:24] inside {8'h06, 8'h46})) |=> s_r.ack == 8'hD6)
		else $error("config byte not taken from byte 0");
	a_hdr_reject: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_128
		&& i_tag.header != 16'h802A)) |=> s_r.ack[5:1] != trch_pkg::FLAG_OK)
		else $error("wrong header accepted");
	a_data_msb: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_128))
		|=> s_r.shift == $past(i_tag.data))
		else $error("128-bit data not loaded msb first");
	a_forty_align: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_40))
		|=> s_r.shift[127:88] == $past(i_tag.data[39:0]))
		else $error("40-bit data not placed msb first");
	a_pw_fail: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_PW && i_tag.present
		&& cfg_usable && !i_tag.pw_ok)) |=> s_r.ack == 8'hC4)
		else $error("password failure not flagged");
	a_absent_ack: assert property ((s_tag_done and (i_mode == trch_pkg::TRCH_MODE_40 && !i_tag.present))
		|=> s_r.ack == 8'hC0)
		else $error("missing tag not flagged");
	a_last_byte: assert property (s_r.st == ST_DATA && f_ready && s_r.left == 5'h01
		|=> s_r.st == ST_IDLE)
		else $error("reply ran past its length");
endmodule : trch_handler

// >>> rtl/trch_pkg.sv
// Purpose: shared constants and carriers of the tag read command handler
// Assumes: byte wide host link, tag front end on the same clock
// Notes:   ack byte is 1 1 F F F F F x, flags in bits 5..1
package trch_pkg;
	localparam logic [7:0]   CMD_READ      = 8'h52;
	localparam logic [7:0]   ACK_BASE      = 8'hC0;
	localparam logic [4:0]   FLAG_OK       = 5'h0B;
	localparam logic [4:0]   FLAG_NO_TAG   = 5'h00;
	localparam logic [4:0]   FLAG_TAG_PW   = 5'h02;
	localparam logic [7:0]   CFG_OPEN      = 8'h06;
	localparam logic [7:0]   CFG_LOCKED    = 8'h46;
	localparam logic [2:0]   CFG_PAGE      = 3'h3;
	localparam logic [15:0]  HDR_128       = 16'h802A;
	localparam logic [4:0]   LEN_40        = 5'h05;
	localparam logic [4:0]   LEN_128       = 5'h10;
	localparam logic [4:0]   LEN_PW        = 5'h04;
	localparam int           FIFO_W        = 8;
	localparam int           FIFO_D        = 16;

	typedef enum logic [1:0] {
		TRCH_MODE_PW,
		TRCH_MODE_40,
		TRCH_MODE_128
	} trch_mode_t;

	// one-cycle answer of the rf front end
	typedef struct packed {
		logic         done;
		logic         present;
		logic         pw_ok;
		logic         rf64_ask_manch;
		logic [15:0]  header;
		logic [31:0]  cfg_word;
		logic [127:0] data;
	} trch_tag_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} trch_byte_t;
endpackage : trch_pkg

// >>> test/tb_trch_handler.sv
// Purpose: bench of the tag read command handler
// Assumes: host model sends commands, bench plays the rf front end
// Notes:   row table first, then junk byte and reset cases
`timescale 1ns/1ps
module tb_trch_handler;
	typedef struct packed {
		trch_pkg::trch_mode_t mode;
		logic [3:0]           f;
		logic [15:0]          hdr;
		logic [7:0]           cfg;
		logic [7:0]           ack;
		logic [4:0]           n;
	} trch_row_t;
	localparam trch_pkg::trch_mode_t MP = trch_pkg::TRCH_MODE_PW;
	localparam trch_pkg::trch_mode_t M4 = trch_pkg::TRCH_MODE_40;
	localparam trch_pkg::trch_mode_t M1 = trch_pkg::TRCH_MODE_128;
	localparam logic [127:0]         D  = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	// f: present, password ok, rf64 manchester, slow host
	localparam trch_row_t ROWS [10] = '{
		'{M4, 4'hE, 16'h802A, 8'h06, 8'hD6, 5'h05}, '{M4, 4'h6, 16'h802A, 8'h06, 8'hC0, 5'h00},
		'{M1, 4'hF, 16'h802A, 8'h06, 8'hD6, 5'h10}, '{M1, 4'hE, 16'h802B, 8'h06, 8'hC0, 5'h00},
		'{M1, 4'hC, 16'h802A, 8'h06, 8'hC0, 5'h00}, '{M1, 4'h6, 16'h802A, 8'h06, 8'hC0, 5'h00},
		'{MP, 4'hE, 16'h802A, 8'h06, 8'hD6, 5'h04}, '{MP, 4'hF, 16'h802A, 8'h46, 8'hD6, 5'h04},
		'{MP, 4'hE, 16'h802A, 8'h07, 8'hC0, 5'h00}, '{MP, 4'hA, 16'h802A, 8'h06, 8'hC4, 5'h00}};
	logic                    i_core_clk;
	logic                    i_rst;
	logic                    o_cmd_ready;
	logic                    rsp_ready;
	logic                    o_tag_req;
	logic                    o_busy;
	logic [2:0]              tag_page;
	logic                    slow;
	trch_pkg::trch_mode_t    i_mode;
	trch_pkg::trch_byte_t    cmd;
	trch_pkg::trch_byte_t    o_rsp;
	trch_pkg::trch_tag_rsp_t i_tag;
	trch_row_t               row;
	int                      mismatches;
	int                      checked;
	int                      w;
	trch_handler #(.DEPTH(16)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mode(i_mode), .i_cmd(cmd),
		.o_cmd_ready(o_cmd_ready), .o_rsp(o_rsp), .i_rsp_ready(rsp_ready), .o_tag_req(o_tag_req),
		.o_tag_page(tag_page), .i_tag(i_tag), .o_busy(o_busy));
	trch_host host (.i_core_clk(i_core_clk), .i_slow(slow), .o_cmd(cmd), .i_cmd_ready(o_cmd_ready),
		.i_rsp(o_rsp), .o_rsp_ready(rsp_ready));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge i_core_clk) #1;
	endtask : tick
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	initial begin
		i_rst = 1'b1;
		i_mode = M4;
		i_tag = '0;
		slow = 1'b0;
		mismatches = 0;
		checked = 0;
		tick(3);
		i_rst = 1'b0;
		for (int r = 0; r < 10; r++) begin
			row = ROWS[r];
			slow = row.f[0];
			i_mode = row.mode;
			host.got.delete();
			host.read_cmd(trch_pkg::CMD_READ, 8'h03);
			for (w = 0; w < 50 && o_tag_req !== 1'b1; w++) tick(1);
			if (w == 50) begin
				mismatches++;
				test_done();
			end
			check(tag_page, (row.mode == MP) ? 16'h0003 : 16'h0000);
			tick(1);
			i_tag = '{1'b1, row.f[3], row.f[2], row.f[1], row.hdr, {row.cfg, 24'hAA4854}, D};
			tick(1);
			i_tag.done = 1'b0;
			for (w = 0; w < 2000 && host.got.size() < row.n + 1; w++) tick(1);
			if (w == 2000) begin
				mismatches++;
				test_done();
			end
			tick(20);
			check(host.got.size(), row.n + 1);
			check(host.got[0], row.ack);
			for (int k = 0; k < row.n; k++) check(host.got[k+1], D[(row.n-1-k)*8 +: 8]);
			check(o_busy, 1'b0);
			$display("row %0d done", r);
		end
		// bytes other than the read code leave the handler idle
		host.got.delete();
		host.read_cmd(8'h11, 8'h11);
		tick(3);
		check(o_busy, 1'b0);
		check(host.got.size(), 16'h0000);
		$display("junk byte test done");
		host.read_cmd(trch_pkg::CMD_READ, 8'h00);
		tick(2);
		i_rst = 1'b1;
		tick(3);
		check({o_busy, o_rsp.valid, o_cmd_ready}, 3'b001);
		i_rst = 1'b0;
		// first edge after release already takes the command byte
		host.read_cmd(trch_pkg::CMD_READ, 8'h00);
		check(o_tag_req, 1'b1);
		check(host.stalls, 16'h0000);
		$display("reset test done");
		test_done();
	end
endmodule : tb_trch_handler

// >>> test/trch_host.sv
// Purpose: host model, sends read commands and collects reply bytes
// Assumes: one command in flight at a time
// Notes:   slow mode takes a byte once in 64 cycles so the reply fifo fills
`timescale 1ns/1ps
module trch_host (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_slow,
	output trch_pkg::trch_byte_t      o_cmd,
	input  wire logic                 i_cmd_ready,
	input  wire trch_pkg::trch_byte_t i_rsp,
	output logic                      o_rsp_ready
);
	logic [7:0] got [$];
	logic [5:0] ph;
	int         stalls;
	initial begin
		stalls = 0;
		o_cmd = '0;
		o_rsp_ready = 1'b0;
		ph = 6'h00;
	end
	// every byte kept, flags judged afterwards by the reader of got
	always @(posedge i_core_clk) begin
		if (o_rsp_ready && i_rsp.valid) got.push_back(i_rsp.data);
		ph = ph + 6'h01;
		#1 o_rsp_ready = ~i_slow | (ph == 6'h00);
	end
	// byte held until an edge where ready is high, or given up after 50 edges with ready low
	task automatic take(input logic [7:0] b);
		int i;
		o_cmd = {1'b1, b};
		for (i = 0; i < 50 && !i_cmd_ready; i++) @(posedge i_core_clk) #1;
		if (i == 50) stalls++;
		@(posedge i_core_clk) #1;
	endtask : take
	task automatic read_cmd(input logic [7:0] c, input logic [7:0] arg);
		take(c);
		take(arg);
		o_cmd = '0;
	endtask : read_cmd
endmodule : trch_host
